/* sams_defs.svh */
`ifndef SAMS_DEFS_SVH
`define SAMS_DEFS_SVH

// Register bus geometry
`define SAMS_AXI_AW 12
`define SAMS_CTRL_OFF 12'h000
`define SAMS_STAT_OFF 12'h004
`define SAMS_RESP_OKAY 2'h0
`define SAMS_RESP_SLVERR 2'h2

// Control register: bit 0 lets the sequencer respond to select
`define SAMS_CTRL_EN_BIT 0
`define SAMS_CTRL_RESET 1'h1

// Status register layout: result, activity, state code
`define SAMS_STAT_CA_BIT 8
`define SAMS_STAT_ST_LSB 9

// Conversion geometry
`define SAMS_RESULT_W 8
`define SAMS_RESULT_LAST 3'h7
`define SAMS_WORD_W 4
`define SAMS_WORD_LAST 3'h3
`define SAMS_TRIAL_FIRST 8'h80

`endif

/* sams_pkg.sv */
`default_nettype none
`include "sams_defs.svh"

package sams_pkg;

   // Sequencer phases, one per stretch of the serial frame
   typedef enum logic [2:0] {
      SAMS_IDLE, SAMS_ADDR, SAMS_SETTLE, SAMS_MSB, SAMS_LSB, SAMS_LOW
   } sams_state_e;

   // Everything that select must clear
   typedef struct packed {
      sams_state_e st;
      logic started;
      logic [2:0] cnt;
      logic [`SAMS_WORD_W-1:0] word;
      logic [`SAMS_RESULT_W-1:0] approximation_register;
      logic [`SAMS_RESULT_W-1:0] trial;
      logic [1:0] plus;
      logic [1:0] minus;
      logic common;
      logic mux_en;
      logic do_q;
      logic do_oe_n;
      logic ca;
      logic ca_oe_n;
   } sams_seq_s;

   // Whole module state
   typedef struct packed {
      sams_seq_s seq;
      logic sclk_q;
      logic enable;
      logic aw_have;
      logic [`SAMS_AXI_AW-1:0] awaddr;
      logic w_have;
      logic wbit;
      logic wlane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sams_regs_s;

endpackage : sams_pkg

`default_nettype wire

/* sams_sequencer.sv */
// Overview of operation
// - Positive below negative yields all-zero result
// - Differential pairs only 0/1 and 2/3
// - Single-ended converts one channel against common
// - Differential: pair bit, polarity bit picks positive
// - Exactly four assignment bits follow start bit
// - Address bits sampled on rising converter clock
// - Leading zeros ignored; first one starts
// - Half-clock settling after the last assignment bit
// - Status high at settling; input then ignored
// - Output leaves high-Z with one leading zero
// - Decisions leave on falling edges, MSB first
// - Eight periods; status drops half clock later
// - Result repeated LSB first after MSB stream
// - Output low afterwards until select rises
// - Select high clears the sequencer registers but sets both output enables high
// - Input observed only while output high-Z
// - Fresh assignment word every conversion
// - Select high floats output and status
`default_nettype none
`include "sams_defs.svh"

module sams_sequencer
   import sams_pkg::*;
(
   // System clock and reset
   input wire logic clock,
   input wire logic nrst,
   // AXI4-Lite write channels
   input wire logic [`SAMS_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [`SAMS_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Host serial pins
   input wire logic select_n,
   input wire logic sclk,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe_n,
   output logic conversion_active,
   output logic conversion_active_oe_n,
   // Analog front end
   input wire logic comparator_high,
   output logic [`SAMS_RESULT_W-1:0] trial_code,
   output logic mux_enable,
   output logic [1:0] mux_plus_sel,
   output logic [1:0] mux_minus_sel,
   output logic mux_minus_common
);

   sams_regs_s s_q; // Registered state
   sams_regs_s s_d; // Next state
   logic sclk_rise; // Converter clock rose this cycle
   logic sclk_fall; // Converter clock fell this cycle
   logic held; // Sequencer held clear by select or control

   // Single bit mask for a result position, MSB at index 0
   function automatic logic [`SAMS_RESULT_W-1:0] bit_mask(
      input logic [2:0] idx);
      bit_mask = `SAMS_TRIAL_FIRST >> idx;
   endfunction

   // Word layout: [3] single, [2] odd, [1] pair, [0] always one
   function automatic logic [4:0] mux_decode(
      input logic [`SAMS_WORD_W-1:0] w);
      logic [1:0] pos;
      logic [1:0] neg;
      pos = {w[1], w[2]};
      neg = {w[1], ~w[2]}; // neighbour of the same pair only
      mux_decode = {pos, neg, w[3]}; // common return when single
   endfunction

   // Edges are seen from the last sample; inputs are synchronous
   assign sclk_rise = sclk & ~s_q.sclk_q;
   assign sclk_fall = ~sclk & s_q.sclk_q;
   assign held = select_n | ~s_q.enable;

   // Next-state logic for bus slave and sequencer
   always_comb begin
      s_d = s_q;
      s_d.sclk_q = sclk;

      // Write address and data are taken in either order
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wbit = s_axi_wdata[`SAMS_CTRL_EN_BIT];
         s_d.wlane0 = s_axi_wstrb[0];
      end
      // Response once both halves are in
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         if (s_q.awaddr == `SAMS_CTRL_OFF) begin
            s_d.bresp = `SAMS_RESP_OKAY;
            if (s_q.wlane0) begin
               s_d.enable = s_q.wbit;
            end
         end else if (s_q.awaddr == `SAMS_STAT_OFF) begin
            // Status is read only; writes are dropped quietly
            s_d.bresp = `SAMS_RESP_OKAY;
         end else begin
            s_d.bresp = `SAMS_RESP_SLVERR;
         end
      end else if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // Stall both write channels until the response is gone
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;

      // Read channel: one outstanding read at a time
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = `SAMS_RESP_OKAY;
         s_d.rdata = 32'h0;
         if (s_axi_araddr == `SAMS_CTRL_OFF) begin
            s_d.rdata[`SAMS_CTRL_EN_BIT] = s_q.enable;
         end else if (s_axi_araddr == `SAMS_STAT_OFF) begin
            s_d.rdata[`SAMS_RESULT_W-1:0] = s_q.seq.approximation_register;
            s_d.rdata[`SAMS_STAT_CA_BIT] = s_q.seq.ca;
            s_d.rdata[`SAMS_STAT_ST_LSB +: 3] = s_q.seq.st;
         end else begin
            s_d.rresp = `SAMS_RESP_SLVERR;
         end
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      s_d.arready = !s_d.rvalid;

      // Sequencer: past SAMS_IDLE only converter clock edges move it, so a clock
      // parked low simply freezes the phase
      if (held) begin
         s_d.seq = '0; // nothing survives a frame
         s_d.seq.do_oe_n = 1'b1;
         s_d.seq.ca_oe_n = 1'b1;
      end else begin
         case (s_q.seq.st)
            SAMS_IDLE: begin
               // Select has just fallen; wait for the start bit
               s_d.seq.st = SAMS_ADDR;
            end
            SAMS_ADDR: begin
               // Input is looked at only here, output still high-Z
               if (sclk_rise) begin
                  if (!s_q.seq.started) begin
                     s_d.seq.started = serial_in;
                  end else begin
                     s_d.seq.word = {s_q.seq.word[2:0], serial_in};
                     if (s_q.seq.cnt == `SAMS_WORD_LAST) begin
                        {s_d.seq.plus, s_d.seq.minus,
                         s_d.seq.common} = mux_decode(s_d.seq.word);
                        s_d.seq.mux_en = 1'b1;
                        s_d.seq.cnt = 3'h0;
                        s_d.seq.st = SAMS_SETTLE;
                     end else begin
                        s_d.seq.cnt = s_q.seq.cnt + 3'h1;
                     end
                  end
               end
            end
            SAMS_SETTLE: begin
               // Half a clock of settling ends at the falling edge
               if (sclk_fall) begin
                  s_d.seq.ca = 1'b1;
                  s_d.seq.ca_oe_n = 1'b0;
                  s_d.seq.do_q = 1'b0;
                  s_d.seq.do_oe_n = 1'b0;
                  s_d.seq.trial = `SAMS_TRIAL_FIRST;
                  s_d.seq.st = SAMS_MSB;
               end
            end
            SAMS_MSB: begin
               // A reversed input never beats any trial, so every
               // decision is low and the result is all zeros
               if (sclk_fall) begin
                  s_d.seq.approximation_register[`SAMS_RESULT_LAST - s_q.seq.cnt] =
                     comparator_high;
                  s_d.seq.do_q = comparator_high;
                  if (s_q.seq.cnt == `SAMS_RESULT_LAST) begin
                     s_d.seq.trial = s_d.seq.approximation_register;
                     s_d.seq.cnt = 3'h1;
                     s_d.seq.st = SAMS_LSB;
                  end else begin
                     s_d.seq.trial = s_d.seq.approximation_register |
                        bit_mask(s_q.seq.cnt + 3'h1);
                     s_d.seq.cnt = s_q.seq.cnt + 3'h1;
                  end
               end
            end
            SAMS_LSB: begin
               // Bit 0 was the last MSB-first bit and is shared
               if (sclk_rise) begin
                  s_d.seq.ca = 1'b0;
               end
               if (sclk_fall) begin
                  s_d.seq.do_q = s_q.seq.approximation_register[s_q.seq.cnt];
                  if (s_q.seq.cnt == `SAMS_RESULT_LAST) begin
                     s_d.seq.st = SAMS_LOW;
                  end else begin
                     s_d.seq.cnt = s_q.seq.cnt + 3'h1;
                  end
               end
            end
            SAMS_LOW: begin
               if (sclk_fall) begin
                  s_d.seq.do_q = 1'b0;
               end
            end
            default: begin
               s_d.seq.st = SAMS_IDLE;
            end
         endcase
      end
   end

   // State register; reset takes constants only
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.enable <= `SAMS_CTRL_RESET;
         s_q.seq.do_oe_n <= 1'b1;
         s_q.seq.ca_oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Every output comes straight from the state register
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign serial_out = s_q.seq.do_q;
   assign serial_out_oe_n = s_q.seq.do_oe_n;
   assign conversion_active = s_q.seq.ca;
   assign conversion_active_oe_n = s_q.seq.ca_oe_n;
   assign trial_code = s_q.seq.trial;
   assign mux_enable = s_q.seq.mux_en;
   assign mux_plus_sel = s_q.seq.plus;
   assign mux_minus_sel = s_q.seq.minus;
   assign mux_minus_common = s_q.seq.common;

   // Checks on the sequencer
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   AST_SELECT_FLOATS: assert property (
      select_n |=> serial_out_oe_n && conversion_active_oe_n
         && !conversion_active && s_q.seq.st == SAMS_IDLE)
      else $error("select high did not clear and float outputs");

   AST_INPUT_WHILE_FLOAT: assert property (
      s_q.seq.st == SAMS_ADDR |-> serial_out_oe_n)
      else $error("output driven during addressing");

   AST_LEADING_ZERO: assert property (
      s_q.seq.st == SAMS_ADDR && !s_q.seq.started && sclk_rise
         && !serial_in && !held |=> !s_q.seq.started)
      else $error("zero taken as start bit");

   AST_SETTLE_START: assert property (
      s_q.seq.st == SAMS_SETTLE && sclk_fall && !held
         |=> conversion_active && !serial_out && !serial_out_oe_n
         ##0 s_q.seq.st == SAMS_MSB)
      else $error("settling did not raise status with leading zero");

   AST_MSB_DECISION: assert property (
      s_q.seq.st == SAMS_MSB && sclk_fall && !held
         |=> serial_out == $past(comparator_high)
         && s_q.seq.approximation_register[3'h7 - $past(s_q.seq.cnt)] ==
            $past(comparator_high))
      else $error("decision not driven or stored");

   AST_STATUS_DROP: assert property (
      s_q.seq.st == SAMS_LSB && sclk_rise && !held
         |=> !conversion_active && !conversion_active_oe_n)
      else $error("status did not drop after conversion");

   AST_LSB_REPLAY: assert property (
      s_q.seq.st == SAMS_LSB && sclk_fall && !held
         |=> serial_out == $past(s_q.seq.approximation_register[s_q.seq.cnt]))
      else $error("LSB-first bit differs from result");

   // B7 of the LSB-first stream still stands for one period in the low
   // phase; the tail starts at the next fall and must then stay low
   AST_TAIL_LOW: assert property (
      s_q.seq.st == SAMS_LOW && (sclk_fall || !serial_out) && !held
         |=> !serial_out && !serial_out_oe_n)
      else $error("output not held low after readout");

   AST_PAIR_ADJACENT: assert property (
      mux_enable && !mux_minus_common
         |-> mux_plus_sel[1] == mux_minus_sel[1]
         && mux_plus_sel[0] != mux_minus_sel[0])
      else $error("differential pair not adjacent");

endmodule // sams_sequencer

`default_nettype wire

/* sams_host_model.sv */
`default_nettype none

module sams_host_model
   import sams_pkg::*;
#(
   parameter int HALF = 4
)
(
   // Clock
   input wire logic clock,
   // Serial pins toward the sequencer
   output logic select_n,
   output logic sclk,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   input wire logic conversion_active,
   // Mux outputs, only watched
   input wire logic [5:0] mux_view
);
   timeunit 1ns;
   timeprecision 1ps;

   // Data line let go: it toggles so a stale level never passes
   logic rel;

   initial begin
      select_n = 1'h1;
      sclk = 1'h0;
      serial_in = 1'h0;
      rel = 1'h1;
   end

   // Waits n edges, toggling a released data line each cycle
   task automatic wait_edges(input int n);
      repeat (n) begin
         @(posedge clock);
         if (rel) serial_in <= ~serial_in;
      end
   endtask

   // One frame; so/ca/oe hold what each low half ended with
   task automatic frame(input logic [3:0] word, input int zeros,
      input int steps, input int stall, output logic [16:0] so,
      output logic [16:0] ca, output logic [16:0] oe,
      output logic [5:0] mx);
      so = '0;
      ca = '0;
      oe = '1;
      mx = '0;
      select_n <= 1'h0;
      wait_edges(1);
      // Take the line back before the edge that drives the first bit
      rel = 1'h0;
      wait_edges(1);
      // Leading zeros, start bit, then the word MSB first
      for (int i = 0; i < zeros + 5; i++) begin
         serial_in <= (i < zeros) ? 1'h0 : (i == zeros) ? 1'h1 :
            word[zeros + 4 - i];
         wait_edges(HALF);
         sclk <= 1'h1;
         wait_edges(HALF);
         sclk <= 1'h0;
      end
      rel = 1'h1;
      // Clock may idle low mid-frame; output must stay put then
      for (int i = 0; i < steps; i++) begin
         wait_edges(HALF + ((i == 4) ? stall : 0));
         so[i] = serial_out;
         ca[i] = conversion_active;
         oe[i] = serial_out_oe_n;
         if (i == 0) mx = mux_view;
         sclk <= 1'h1;
         wait_edges(HALF);
         sclk <= 1'h0;
      end
      select_n <= 1'h1;
      wait_edges(3);
   endtask
endmodule // sams_host_model

`default_nettype wire

/* tb_serial_adc_mux_sequencer.sv */
`default_nettype none
`include "sams_defs.svh"

module tb_serial_adc_mux_sequencer
   import sams_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Nets named as the design ports
   logic clock, nrst;
   logic [`SAMS_AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, mux_plus_sel, mux_minus_sel;
   logic select_n, sclk, serial_in, serial_out, serial_out_oe_n;
   logic conversion_active, conversion_active_oe_n, comparator_high;
   logic mux_enable, mux_minus_common, neg;
   logic [7:0] trial_code, vin;
   logic [7:0] vt [8] = '{8'hc3, 8'hff, 8'h00, 8'ha5, 8'h5a, 8'h01,
      8'h80, 8'h7f};
   int err_total = 0;
   int checked = 0;

   // 200 MHz clock
   initial begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end

   // Input sits half a step above vin, so the result equals vin
   always @(posedge clock)
      comparator_high <= !neg && (trial_code <= vin);

   sams_sequencer DUT (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .select_n, .sclk,
      .serial_in, .serial_out, .serial_out_oe_n, .conversion_active,
      .conversion_active_oe_n, .comparator_high, .trial_code,
      .mux_enable, .mux_plus_sel, .mux_minus_sel, .mux_minus_common);

   sams_host_model #(.HALF(4)) host (.clock, .select_n, .sclk,
      .serial_in, .serial_out, .serial_out_oe_n, .conversion_active,
      .mux_view({mux_enable, mux_minus_common, mux_plus_sel,
      mux_minus_sel}));

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic complete_run();
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Write: address and data offered together, each held until taken
   task automatic axw(input logic [`SAMS_AXI_AW-1:0] a,
      input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   // Read: rready held until the answer is seen
   task automatic axr(input logic [`SAMS_AXI_AW-1:0] a,
      output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      complete_run();
   end

   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [16:0] so, ca, oe, exp;
      logic [5:0] mx;
      logic [3:0] w;
      nrst = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, neg} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      vin = vt[7];
      repeat (20) @(posedge clock);
      nrst <= 1'h1;
      repeat (2) @(posedge clock);
      // Register map, unmapped place and read-only status
      axr(`SAMS_CTRL_OFF, d, r);
      check(d, 32'h1);
      axr(12'h008, d, r);
      check(d, 32'h0);
      check(32'(r), 32'(`SAMS_RESP_SLVERR));
      axw(12'h008, 32'h1, r);
      check(32'(r), 32'(`SAMS_RESP_SLVERR));
      axw(`SAMS_STAT_OFF, 32'hffffffff, r);
      check(32'(r), 32'(`SAMS_RESP_OKAY));
      axr(`SAMS_STAT_OFF, d, r);
      check(d, 32'h0);
      // Frame cut short by select in the MSB stream
      host.frame(4'hb, 1, 5, 0, so, ca, oe, mx);
      check(32'(so[4:1]),
         32'({vt[7][4], vt[7][5], vt[7][6], vt[7][7]}));
      check(32'({serial_out_oe_n, conversion_active_oe_n}), 32'h3);
      // Every assignment code, with varied leading zeros
      for (int k = 0; k < 8; k++) begin
         w = {k[2:0], 1'h1};
         vin <= vt[k];
         neg <= (k == 0);
         host.frame(w, k % 4, 17, (k == 5) ? 40 : 0, so, ca, oe, mx);
         exp = '0;
         for (int j = 0; j < 8; j++) exp[8 - j] = vt[k][j] && k != 0;
         for (int j = 1; j < 8; j++) exp[8 + j] = vt[k][j] && k != 0;
         check(32'(so), 32'(exp));
         check(32'(ca), 32'h1ff);
         check(32'(oe), 32'h0);
         check(32'(mx[5:2]), 32'({1'h1, w[3], w[1], w[2]}));
         if (!w[3]) check(32'(mx[1:0]), 32'({w[1], ~w[2]}));
         check(32'({serial_out_oe_n, conversion_active_oe_n,
            mux_enable}), 32'h6);
      end
      // Disabled sequencer ignores select
      axw(`SAMS_CTRL_OFF, 32'h0, r);
      axr(`SAMS_CTRL_OFF, d, r);
      check(d, 32'h0);
      host.frame(4'hf, 0, 3, 0, so, ca, oe, mx);
      check(32'(oe[2:0]), 32'h7);
      axw(`SAMS_CTRL_OFF, 32'h1, r);
      complete_run();
   end
endmodule // tb_serial_adc_mux_sequencer

`default_nettype wire
